/* dv/e3_overhead_insert_strobe_port_tb_top.sv */
// top testbench for the overhead insert strobe port
`timescale 1ns/1ps
`include "ovh_regs.svh"

module e3_overhead_insert_strobe_port_tb_top;
   import ovh_pkg::*;
   localparam int FB = 96;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic payload_bit = 1'b0;
   logic payload_take, line_data, line_ovh, line_frame, acc, rej, locked;
   logic [5:0] cur_slot;
   logic [15:0] acc_cnt, rej_cnt;
   logic [39:0] int_ovh = '0;
   logic [55:0] ins_mask = '0;
   logic [55:0] ins_value = '0;
   logic [3:0] note_q[$];
   logic [3:0] nt;
   logic have_p = 1'b0;
   logic p_bit = 1'b0;
   logic [7:0] bip_run = 8'h00;
   logic [7:0] bip_exp = 8'h00;
   logic bip_ok = 1'b0;
   logic bip_seen = 1'b0;
   int ln = 0;
   int bad_count = 0;
   int n_tests = 0;
   int exp_acc = 0;
   int exp_rej = 0;

   always #25 clk_sys = ~clk_sys;

   // ----
   // both ends and the checker
   // ----
   ovh_if i_ovh_if (.clk_sys(clk_sys));
   // short frame keeps the run brief; device and checker both take FB, rows stay at 16 bits
   ovh_dev #(.FRAME_BITS(FB), .ROW_BITS(16)) i_ovh_dev (.clk_sys(clk_sys), .nrst(nrst),
      .link(i_ovh_if.dev), .payload_bit(payload_bit), .payload_take(payload_take),
      .int_ovh(int_ovh), .line_data(line_data), .line_ovh(line_ovh),
      .line_frame(line_frame), .insert_accepted(acc), .insert_rejected(rej),
      .accepted_count(acc_cnt), .rejected_count(rej_cnt));
   ovh_term i_ovh_term (.clk_sys(clk_sys), .nrst(nrst), .link(i_ovh_if.term),
      .ins_mask(ins_mask), .ins_value(ins_value), .locked(locked), .cur_slot(cur_slot));
   ovh_port_assertions #(.FRAME_BITS(FB)) i_ovh_port_assertions (.clk_sys(clk_sys),
      .nrst(nrst), .ovh_bit_in(i_ovh_if.ovh_bit_in),
      .ovh_frame_start_marker(i_ovh_if.ovh_frame_start_marker),
      .ovh_slot_strobe(i_ovh_if.ovh_slot_strobe),
      .ovh_insert_request(i_ovh_if.ovh_insert_request), .line_data(line_data),
      .line_ovh(line_ovh), .line_frame(line_frame), .insert_accepted(acc),
      .insert_rejected(rej));

   // ----
   // tasks
   // ----
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // notes per slot: check data, data or monitor flag, accepted, rejected
   task automatic plan_frame(input logic [55:0] m, input logic [55:0] v);
      logic b;
      logic [15:0] al;
      al = {`OVH_FIRST_ALIGN_DEFAULT, `OVH_SECOND_ALIGN_DEFAULT};
      ins_mask = m;
      ins_value = v;
      int_ovh = 40'({$urandom, $urandom});
      for (int s = 0; s < 56; s++)
      begin
         b = m[55 - s];
         exp_acc += (s > 23 && b) ? 1 : 0;
         exp_rej += (s < 24 && b) ? 1 : 0;
         if (s < 16)
            note_q.push_back({1'b1, al[15 - s], 1'b0, b});
         else if (s < 24)
            note_q.push_back({2'b01, 1'b0, b});
         else
            note_q.push_back({1'b1, b ? v[55 - s] : int_ovh[63 - s], b, 1'b0});
      end
   endtask

   // ----
   // stimulus
   // ----
   always @(posedge clk_sys)
      #1 payload_bit = 1'($urandom);

   // ----
   // watcher: outputs settle by the falling edge
   // ----
   always @(negedge clk_sys)
   begin
      if (!nrst)
      begin
         have_p = 1'b0;
         bip_seen = 1'b0;
         bip_ok = 1'b0;
      end
      else
      begin
         // monitor byte carries parity of the whole previous frame
         if (line_frame === 1'b1)
         begin
            bip_ok = bip_seen;
            bip_seen = 1'b1;
            bip_exp = bip_run;
            bip_run = 8'h00;
            ln = 0;
         end
         if (line_ovh === 1'b1)
         begin
            check("note queue", 16'(note_q.size() > 0), 16'h0001);
            nt = note_q.pop_front();
            if (nt[3])
               check("overhead bit", 16'(line_data), 16'(nt[2]));
            else if (nt[2] && bip_ok)
               check("monitor bit", 16'(line_data), 16'(bip_exp[7 - ln % 8]));
            check("accepted", 16'(acc), 16'(nt[1]));
            check("rejected", 16'(rej), 16'(nt[0]));
         end
         else if (have_p)
            check("payload bit", 16'(line_data), 16'(p_bit));
         bip_run[7 - ln % 8] ^= line_data;
         ln++;
         have_p = payload_take;
         p_bit = payload_bit;
      end
   end

   initial
   begin
      void'($urandom(28));
      plan_frame('0, '0);
      repeat (20) @(posedge clk_sys);
      #1 nrst = 1'b1;
      for (int t = 0; t < 7; t++)
      begin
         while (note_q.size() != 0)
            @(posedge clk_sys);
         $display("frame test %0d done", t);
         @(posedge clk_sys);
         #1;
         // locked slots first, then every slot, then random picks
         if (t < 6)
            plan_frame(t == 0 ? {24'hFFFFFF, 32'h0} : t == 1 ? '1 : 56'({$urandom, $urandom}),
               56'({$urandom, $urandom}));
      end
      check("accepted count", acc_cnt, 16'(exp_acc));
      check("rejected count", rej_cnt, 16'(exp_rej));
      check("locked", 16'(locked), 16'h0001);
      check("current slot", 16'(cur_slot), 16'h0037);
      tally_and_finish();
   end

   initial
   begin
      repeat (3000) @(posedge clk_sys);
      bad_count++;
      tally_and_finish();
   end
endmodule

/* dv/ovh_port_assertions.sv */
// checker for the overhead insert strobe link
`timescale 1ns/1ps

module ovh_port_assertions
#(
   parameter int FRAME_BITS = 4296
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ovh_bit_in,
   input wire logic ovh_frame_start_marker,
   input wire logic ovh_slot_strobe,
   input wire logic ovh_insert_request,
   input wire logic line_data,
   input wire logic line_ovh,
   input wire logic line_frame,
   input wire logic insert_accepted,
   input wire logic insert_rejected
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [12:0] gap_reg;
   logic [6:0] scnt_reg;
   logic [5:0] slot_reg;

   // ----
   // helper counters
   // ----
   // reset values act like a marked strobe, as the device shows in reset
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         gap_reg <= 13'(FRAME_BITS - 1);
         scnt_reg <= 7'h38;
         slot_reg <= 6'h00;
      end
      else
      begin
         gap_reg <= ovh_frame_start_marker ? 13'h0000 : gap_reg + 13'h0001;
         if (ovh_slot_strobe)
         begin
            slot_reg <= ovh_frame_start_marker ? 6'h00 : scnt_reg[5:0];
            scnt_reg <= ovh_frame_start_marker ? 7'h01 : scnt_reg + 7'h01;
         end
      end
   end

   // ----
   // link properties
   // ----
   sequence ins_open;
      ovh_insert_request && $past(ovh_slot_strobe) && slot_reg >= 6'h18;
   endsequence
   sequence ins_locked;
      ovh_insert_request && $past(ovh_slot_strobe) && slot_reg < 6'h18;
   endsequence

   marker_strobe_a: assert property (ovh_frame_start_marker |-> ovh_slot_strobe)
      else $error("marker without strobe");
   frame_period_a: assert property (ovh_frame_start_marker |-> gap_reg == FRAME_BITS - 1)
      else $error("marker spacing wrong");
   strobe_count_a: assert property (ovh_frame_start_marker |-> scnt_reg == 7'h38)
      else $error("strobes per frame wrong");
   byte_run_a: assert property ($rose(ovh_slot_strobe) |-> ovh_slot_strobe [*8])
      else $error("strobe run shorter than a byte");
   slot_follows_a: assert property (ovh_slot_strobe |-> ##2 line_ovh)
      else $error("no overhead bit after strobe");
   slot_cause_a: assert property (line_ovh |-> $past(ovh_slot_strobe, 2))
      else $error("overhead bit without strobe");
   frame_flag_a: assert property (ovh_frame_start_marker |-> ##2 line_frame)
      else $error("frame start not followed");
   insert_taken_a: assert property
      (ins_open |=> insert_accepted && line_data == $past(ovh_bit_in))
      else $error("insert not taken");
   insert_refused_a: assert property
      (ins_locked |=> insert_rejected && !insert_accepted)
      else $error("locked slot insert taken");
   request_slot_a: assert property (ovh_insert_request |-> $past(ovh_slot_strobe))
      else $error("request outside slot");
endmodule

/* inc/ovh_if.sv */
// link between the device end and the terminal end
`timescale 1ns/1ps

interface ovh_if
(
   input wire logic clk_sys
);
   logic ovh_bit_in;
   logic ovh_frame_start_marker;
   logic transmit_input_clock;
   logic ovh_slot_strobe;
   logic ovh_insert_request;

   // one clock: the transmit clock is the system clock
   assign transmit_input_clock = clk_sys;

   modport dev
   (
      input ovh_bit_in,
      input transmit_input_clock,
      input ovh_insert_request,
      output ovh_frame_start_marker,
      output ovh_slot_strobe
   );

   modport term
   (
      output ovh_bit_in,
      input transmit_input_clock,
      output ovh_insert_request,
      input ovh_frame_start_marker,
      input ovh_slot_strobe
   );
endinterface

/* inc/ovh_pkg.sv */
// types shared by both ends of the overhead insert strobe port
`include "ovh_regs.svh"

package ovh_pkg;

   typedef logic [`OVH_SLOT_W-1:0] slot_t;
   typedef logic [`OVH_POS_W-1:0] pos_t;

   typedef enum logic {TERM_HUNT, TERM_LOCKED} term_mode_t;

   typedef struct packed {
      pos_t pos;
      logic strobe;
      logic frame;
      logic line_data;
      logic line_ovh;
      logic line_frame;
      logic accepted;
      logic rejected;
      logic [7:0] bip_acc;
      logic [7:0] bip_last;
      logic [`OVH_CNT_W-1:0] acc_cnt;
      logic [`OVH_CNT_W-1:0] rej_cnt;
   } dev_state_t;

   typedef struct packed {
      term_mode_t mode;
      slot_t slot;
      logic ins;
      logic data;
      logic frames_seen;
   } term_state_t;

endpackage

/* inc/ovh_regs.svh */
// constants for the overhead insert strobe port
`ifndef OVH_REGS_SVH
`define OVH_REGS_SVH

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define OVH_FRAME_BITS 4296
`define OVH_ROW_BITS 472
`define OVH_ROWS_WITH_OVH 5
`define OVH_POS_W 13
`define OVH_SLOTS 56
`define OVH_SLOT_W 6

// ----------------------------------------------------------------
// slot map
// ----------------------------------------------------------------
`define OVH_SLOT_FIRST_ALIGN 6'h00
`define OVH_SLOT_SECOND_ALIGN 6'h08
`define OVH_SLOT_ERROR_MON 6'h10
`define OVH_SLOT_TRAIL_TRACE 6'h18
`define OVH_SLOT_MAINT 6'h20
`define OVH_SLOT_REMOTE_DEFECT 6'h20
`define OVH_SLOT_REMOTE_ERROR 6'h21
`define OVH_SLOT_NET_OPER 6'h28
`define OVH_SLOT_GEN_COMMS 6'h30
`define OVH_SLOT_LAST 6'h37
`define OVH_EXT_BITS 40

// ----------------------------------------------------------------
// reset values and counter width
// ----------------------------------------------------------------
`define OVH_FIRST_ALIGN_DEFAULT 8'hAA
`define OVH_SECOND_ALIGN_DEFAULT 8'h55
`define OVH_CNT_W 16

`endif

/* rtl/ovh_dev.sv */
// device end: overhead slot strobes and external overhead insertion
//
// Summary of operation
// - five link signals join both ends
// - device latches insert bit on rising edge
// - terminal samples marker and strobe each period
// - strobe high one period before overhead bit
// - frame marker accompanies strobe before slot zero
// - terminal counts strobes since marked strobe
// - requested bit replaces overhead at its slot, insertable slots 24-55 only
// - slots 0-7 first alignment, not insertable
// - slots 8-15 second alignment, not insertable
// - slots 16-23 error monitor, not insertable
// - slot 23 locked; 24-31 trail trace insertable
// - slots 32-39 maintenance insertable; 32,33 indicators
// - slots 40-55 operator and comms insertable
`timescale 1ns/1ps
`include "ovh_regs.svh"

module ovh_dev
#(
   parameter int FRAME_BITS = `OVH_FRAME_BITS,
   parameter int ROW_BITS = `OVH_ROW_BITS,
   parameter logic [7:0] FIRST_ALIGN = `OVH_FIRST_ALIGN_DEFAULT,
   parameter logic [7:0] SECOND_ALIGN = `OVH_SECOND_ALIGN_DEFAULT
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   ovh_if.dev link,
   input wire logic payload_bit,
   output logic payload_take,
   input wire logic [`OVH_EXT_BITS-1:0] int_ovh,
   output logic line_data,
   output logic line_ovh,
   output logic line_frame,
   output logic insert_accepted,
   output logic insert_rejected,
   output logic [`OVH_CNT_W-1:0] accepted_count,
   output logic [`OVH_CNT_W-1:0] rejected_count
);
   import ovh_pkg::*;

   // ----------------------------------------------------------------
   // slot arithmetic
   // ----------------------------------------------------------------
   function automatic pos_t next_pos(input pos_t p);
      if (p == pos_t'(FRAME_BITS - 1))
      begin
         return '0;
      end
      return p + pos_t'(1);
   endfunction

   // alignment bytes open the frame; later bytes open rows 1..5
   function automatic logic ovh_hit(input pos_t p);
      logic r;
      r = (p < pos_t'(16));
      for (int i = 1; i <= `OVH_ROWS_WITH_OVH; i++)
      begin
         if (p >= pos_t'(i * ROW_BITS) && p < pos_t'(i * ROW_BITS + 8))
         begin
            r = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic slot_t ovh_slot(input pos_t p);
      slot_t s;
      s = slot_t'(p);
      for (int i = 1; i <= `OVH_ROWS_WITH_OVH; i++)
      begin
         if (p >= pos_t'(i * ROW_BITS) && p < pos_t'(i * ROW_BITS + 8))
         begin
            s = slot_t'(8 * (i + 1)) + slot_t'(p - pos_t'(i * ROW_BITS));
         end
      end
      return s;
   endfunction

   function automatic logic insertable(input slot_t s);
      // alignment and error monitor bytes carry framing integrity
      return s >= `OVH_SLOT_TRAIL_TRACE && s <= `OVH_SLOT_LAST;
   endfunction

   function automatic logic internal_bit(input slot_t s, input logic [7:0] bip,
                                         input logic [`OVH_EXT_BITS-1:0] ext);
      logic [2:0] lane;
      lane = 3'(3'h7 - s[2:0]);
      if (s < `OVH_SLOT_SECOND_ALIGN)
      begin
         return FIRST_ALIGN[lane];
      end
      if (s < `OVH_SLOT_ERROR_MON)
      begin
         return SECOND_ALIGN[lane];
      end
      if (s < `OVH_SLOT_TRAIL_TRACE)
      begin
         return bip[lane];
      end
      // slot 32 is remote defect, slot 33 remote error
      return ext[6'(6'h3F - s)];
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   dev_state_t st_reg;
   dev_state_t st_next;
   pos_t pos_n;
   pos_t pos_nn;
   slot_t cur_slot;
   logic cur_ovh;
   logic bit_out;
   logic [7:0] bip_upd;
   logic ins_req;
   logic ins_bit;

   always_comb
   begin
      st_next = st_reg;
      pos_n = next_pos(st_reg.pos);
      pos_nn = next_pos(pos_n);
      cur_ovh = ovh_hit(st_reg.pos);
      cur_slot = ovh_slot(st_reg.pos);
      // request and value are taken together at the edge closing the slot
      ins_req = link.ovh_insert_request;
      ins_bit = link.ovh_bit_in;
      st_next.accepted = 1'b0;
      st_next.rejected = 1'b0;
      st_next.pos = pos_n;
      // strobe leads the overhead bit by exactly one period
      st_next.strobe = ovh_hit(pos_nn);
      st_next.frame = ovh_hit(pos_nn) && ovh_slot(pos_nn) == `OVH_SLOT_FIRST_ALIGN;
      if (cur_ovh)
      begin
         bit_out = internal_bit(cur_slot, st_reg.bip_last, int_ovh);
         if (ins_req && insertable(cur_slot))
         begin
            bit_out = ins_bit;
            st_next.accepted = 1'b1;
            st_next.acc_cnt = st_reg.acc_cnt + 16'h0001;
         end
         else if (ins_req)
         begin
            st_next.rejected = 1'b1;
            st_next.rej_cnt = st_reg.rej_cnt + 16'h0001;
         end
      end
      else
      begin
         bit_out = payload_bit;
      end
      st_next.line_data = bit_out;
      st_next.line_ovh = cur_ovh;
      st_next.line_frame = (st_reg.pos == '0);
      // bit-interleaved parity over the whole frame, lane by bit position
      bip_upd = st_reg.bip_acc ^ (8'(bit_out) << (3'h7 - st_reg.pos[2:0]));
      if (st_reg.pos == pos_t'(FRAME_BITS - 1))
      begin
         st_next.bip_last = bip_upd;
         st_next.bip_acc = 8'h00;
      end
      else
      begin
         st_next.bip_acc = bip_upd;
      end
   end

   // reset lands on the last payload bit with the frame strobe showing,
   // so the very first slot already has its one-period warning
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         // a shortened frame must restart from its own last position
         st_reg <= '{pos: pos_t'(FRAME_BITS - 1),
                     strobe: 1'b1,
                     frame: 1'b1,
                     line_data: 1'b0,
                     line_ovh: 1'b0,
                     line_frame: 1'b0,
                     accepted: 1'b0,
                     rejected: 1'b0,
                     bip_acc: 8'h00,
                     bip_last: 8'h00,
                     acc_cnt: 16'h0000,
                     rej_cnt: 16'h0000};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.ovh_slot_strobe = st_reg.strobe;
   assign link.ovh_frame_start_marker = st_reg.frame;
   assign payload_take = !cur_ovh;
   assign line_data = st_reg.line_data;
   assign line_ovh = st_reg.line_ovh;
   assign line_frame = st_reg.line_frame;
   assign insert_accepted = st_reg.accepted;
   assign insert_rejected = st_reg.rejected;
   assign accepted_count = st_reg.acc_cnt;
   assign rejected_count = st_reg.rej_cnt;

endmodule

/* rtl/ovh_term.sv */
// terminal end: counts slot strobes and requests overhead inserts
`timescale 1ns/1ps
`include "ovh_regs.svh"

module ovh_term
(
   input wire logic clk_sys,
   input wire logic nrst,
   ovh_if.term link,
   input wire logic [`OVH_SLOTS-1:0] ins_mask,
   input wire logic [`OVH_SLOTS-1:0] ins_value,
   output logic locked,
   output ovh_pkg::slot_t cur_slot
);
   import ovh_pkg::*;

   term_state_t st_reg;
   term_state_t st_next;
   logic hit;

   // ----------------------------------------------------------------
   // strobe counting
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      hit = 1'b0;
      st_next.ins = 1'b0;
      st_next.data = 1'b0;
      // one-clock system: the half-period sample lands on this edge
      if (link.ovh_slot_strobe && link.ovh_frame_start_marker)
      begin
         st_next.slot = `OVH_SLOT_FIRST_ALIGN;
         st_next.mode = TERM_LOCKED;
         st_next.frames_seen = 1'b1;
         hit = 1'b1;
      end
      else if (link.ovh_slot_strobe && st_reg.mode == TERM_LOCKED)
      begin
         // a strobe past the last slot means the frame marker was missed
         if (st_reg.slot == `OVH_SLOT_LAST)
         begin
            st_next.mode = TERM_HUNT;
         end
         else
         begin
            st_next.slot = st_reg.slot + 6'h01;
            hit = 1'b1;
         end
      end
      if (hit)
      begin
         st_next.ins = ins_mask[6'(6'h37 - st_next.slot)];
         st_next.data = st_next.ins & ins_value[6'(6'h37 - st_next.slot)];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         st_reg <= '{mode: TERM_HUNT, slot: 6'h00, ins: 1'b0, data: 1'b0,
                     frames_seen: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.ovh_insert_request = st_reg.ins;
   assign link.ovh_bit_in = st_reg.data;
   assign locked = (st_reg.mode == TERM_LOCKED);
   assign cur_slot = st_reg.slot;

endmodule
